// >>> logic/module_flag_irq.sv
// Flag latching, attention output, module reset and management init logic
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
module module_flag_irq
  import module_flag_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Pins and conditions
  input  wire logic        module_reset_n_input,
  input  wire logic        module_present,
  input  wire lane_cond_t  lane_cond,
  input  wire monitor_t    monitors,
  output logic             module_attention_n_output,
  output logic             attention_reset_shared_pin_out,
  output logic             attention_reset_shared_pin_oe,
  output logic             irq,
  output logic             module_ready
);

  localparam int SW = NFLAGS + 2;

  // Address match used by several decoders
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction : hit

  // ==========================================================================
  // Input synchronisers
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;

  // Two flops, third only for edge detect
  always_ff @(posedge clock) begin
    sync1_q <= {module_present, module_reset_n_input, lane_cond};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  wire [NFLAGS-1:0] cond_now   = sync2_q[NFLAGS-1:0];
  wire [NFLAGS-1:0] cond_rise  = sync2_q[NFLAGS-1:0] & ~sync3_q[NFLAGS-1:0];
  wire              rst_pin    = sync2_q[NFLAGS];
  wire              rst_rise   = rst_pin & ~sync3_q[NFLAGS];
  wire              plug_rise  = sync2_q[NFLAGS+1] & ~sync3_q[NFLAGS+1];

  // ==========================================================================
  // Bus slave, one wait cycle per access
  // two-wire bridge drives this port
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         req     = read | write;
  wire         accept  = req & ack_q;
  wire         sel_flg = hit(address, OFS_FLAGS);
  wire         sel_msk = hit(address, OFS_MASK);

  assign waitrequest = req & ~ack_q;
  assign readdata    = rdata_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ==========================================================================
  // Reset pulse width and management state
  mgmt_state_t state_q;
  mgmt_state_t state_d;
  logic [$clog2(RESET_MIN_CYCLES+1)-1:0] low_cnt_q;
  logic [$clog2(INIT_CYCLES+1)-1:0]      init_cnt_q;
  wire armed     = low_cnt_q == RESET_MIN_CYCLES[$bits(low_cnt_q)-1:0];
  wire init_done = init_cnt_q == INIT_CYCLES[$bits(init_cnt_q)-1:0];

  always_ff @(posedge clock) begin
    if (srst || rst_pin) begin
      low_cnt_q <= '0;
    end else if (!armed) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_INIT:  if (init_done) state_d = ST_READY;
      ST_READY: if (armed) state_d = ST_HELD;
                else if (plug_rise) state_d = ST_INIT;
      ST_HELD:  if (rst_rise) state_d = ST_INIT;
      default:  state_d = ST_INIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q    <= ST_INIT;
      init_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      init_cnt_q <= (state_q == ST_INIT && !init_done) ? init_cnt_q + 1'b1 : '0;
    end
  end

  wire ready = state_q == ST_READY;
  assign module_ready = ready;

  // ==========================================================================
  // Flags and mask
  logic [NFLAGS-1:0] flags_q;
  logic [NFLAGS-1:0] mask_q;
  wire               rd_flags = accept & read & sel_flg;
  wire               wr_flags = accept & write & sel_flg;
  wire [NFLAGS-1:0]  w1c      = wr_flags ? writedata[NFLAGS-1:0] : '0;
  wire [NFLAGS-1:0]  pending  = flags_q & ~mask_q;

  generate
    for (genvar i = 0; i < NFLAGS; i++) begin : g_flag
      always_ff @(posedge clock) begin
        if (srst || !ready) begin
          flags_q[i] <= FLAGS_RST[i];
        end else if (cond_rise[i]) begin
          flags_q[i] <= 1'b1;
        end else if (rd_flags || w1c[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      mask_q <= MASK_RST;
    end else if (accept && write && sel_msk) begin
      if (byteenable[0]) mask_q[7:0]  <= writedata[7:0];
      if (byteenable[1]) mask_q[15:8] <= writedata[15:8];
    end
  end

  // ==========================================================================
  // Attention output
  // attention follows pending flags
  assign irq = |pending;
  assign module_attention_n_output      = ~irq;
  // open drain low on shared pin
  assign attention_reset_shared_pin_out = 1'b0;
  assign attention_reset_shared_pin_oe  = irq;

  // ==========================================================================
  // Read data mux
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit(address, OFS_STATUS): rd_mux = {28'h0, irq, state_q, ready};
      sel_flg:                  rd_mux = {16'h0, flags_q};
      sel_msk:                  rd_mux = {16'h0, mask_q};
      hit(address, OFS_RAW):    rd_mux = {16'h0, cond_now};
      hit(address, OFS_TEMP):   rd_mux = {16'h0, monitors.temp};
      hit(address, OFS_TXPWR):  rd_mux = {16'h0, monitors.tx_power};
      hit(address, OFS_RXPWR):  rd_mux = {16'h0, monitors.rx_power};
      hit(address, OFS_VCC):    rd_mux = {16'h0, monitors.supply};
      hit(address, OFS_BIAS):   rd_mux = {16'h0, monitors.bias};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // Capture read data in the wait cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Assertions
  AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (srst)
    (req && !ack_q) |-> waitrequest ##1 (req -> !waitrequest))
    else $error("Bus access not answered after one wait cycle");

  AST_SHORT_PULSE: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_READY && rst_rise && !armed) |=> state_q != ST_INIT)
    else $error("Short reset pulse started a module reset");

  AST_INIT_BOUND: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_INIT && init_done) |=> state_q == ST_READY)
    else $error("Init state did not end at its count");

  AST_FLAG_SET: assert property (@(posedge clock) disable iff (srst)
    (ready && state_d == ST_READY && |cond_rise) |=> (flags_q & $past(cond_rise)) != '0)
    else $error("Condition edge did not set its flag");

  AST_ATTN_ON: assert property (@(posedge clock) disable iff (srst)
    (ready && state_d == ST_READY && |(cond_rise & ~mask_q) && !(accept && write && sel_msk))
    |=> !module_attention_n_output)
    else $error("Attention not asserted after unmasked event");

  AST_COR_CLEAR: assert property (@(posedge clock) disable iff (srst)
    (rd_flags && cond_rise == '0 && state_d == ST_READY) |=> flags_q == '0 ##0 !irq)
    else $error("Flag read did not clear flags and attention");

  AST_MASK_ALL: assert property (@(posedge clock) disable iff (srst)
    (accept && write && sel_msk && byteenable[1:0] == 2'h3 && writedata[15:0] == 16'hFFFF)
    |=> !irq)
    else $error("Full mask did not inhibit attention");

  AST_UNMASK: assert property (@(posedge clock) disable iff (srst)
    (mask_q == '0 && flags_q != '0) |-> !module_attention_n_output)
    else $error("Unmasked flag did not assert attention");

  AST_STICKY: assert property (@(posedge clock) disable iff (srst)
    (flags_q[0] && !rd_flags && !w1c[0] && state_d == ST_READY) |=> flags_q[0])
    else $error("Flag dropped without a clear");

  AST_SHARED_PIN: assert property (@(posedge clock) disable iff (srst)
    attention_reset_shared_pin_oe == !module_attention_n_output)
    else $error("Shared pin enable disagrees with attention");

  AST_PIN_DRIVE_LOW: assert property (@(posedge clock) disable iff (srst)
    attention_reset_shared_pin_oe |-> !attention_reset_shared_pin_out)
    else $error("Shared pin driven high");

  AST_NOT_READY_CLEAR: assert property (@(posedge clock) disable iff (srst)
    !ready |=> flags_q == '0)
    else $error("Flag kept outside ready state");

  AST_PLUG_INIT: assert property (@(posedge clock) disable iff (srst)
    (ready && !armed && plug_rise) |=> state_q == ST_INIT)
    else $error("Hot insertion did not start init");

  AST_HELD_ENTRY: assert property (@(posedge clock) disable iff (srst)
    (ready && armed) |=> state_q == ST_HELD)
    else $error("Long reset pulse did not hold the module");

  AST_RESET_RISE_INIT: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_HELD && rst_rise) |=> state_q == ST_INIT)
    else $error("Reset release did not start init");

  AST_READ_DATA_HELD: assert property (@(posedge clock) disable iff (srst)
    !(read && !ack_q) |=> $stable(readdata))
    else $error("Read data changed without a read");

  AST_WAIT_ONE_CYCLE: assert property (@(posedge clock) disable iff (srst)
    waitrequest |=> !waitrequest)
    else $error("Wait request held for two cycles");

  AST_ACCEPT_AFTER_WAIT: assert property (@(posedge clock) disable iff (srst)
    accept |-> $past(waitrequest))
    else $error("Access accepted without a wait cycle");

  AST_COUNT_BOUND: assert property (@(posedge clock) disable iff (srst)
    low_cnt_q <= RESET_MIN_CYCLES)
    else $error("Reset low counter ran past its limit");

  AST_INIT_COUNT: assert property (@(posedge clock) disable iff (srst)
    state_q == ST_INIT |-> init_cnt_q <= INIT_CYCLES)
    else $error("Init counter ran past its limit");

  AST_STATE_LEGAL: assert property (@(posedge clock) disable iff (srst)
    state_q inside {ST_INIT, ST_READY, ST_HELD})
    else $error("Management state took an unused code");

  AST_W1C_CLEAR: assert property (@(posedge clock) disable iff (srst)
    (wr_flags && writedata[0] && !cond_rise[0]) |=> !flags_q[0])
    else $error("Write one did not clear its flag");

  AST_SET_WINS: assert property (@(posedge clock) disable iff (srst)
    (ready && state_d == ST_READY && cond_rise[0] && rd_flags) |=> flags_q[0])
    else $error("Clear beat a new event");

  AST_ATTN_OFF: assert property (@(posedge clock) disable iff (srst)
    !irq |-> (module_attention_n_output && !attention_reset_shared_pin_oe))
    else $error("Attention held with nothing pending");

  AST_HELD_NO_IRQ: assert property (@(posedge clock) disable iff (srst)
    (state_q == ST_HELD) |=> !irq)
    else $error("Attention raised while module held");

  AST_RDATA_MASK: assert property (@(posedge clock) disable iff (srst)
    (read && !ack_q && sel_msk) |=> readdata == {16'h0, $past(mask_q)})
    else $error("Mask read back wrong");

  AST_RAW_FOLLOWS: assert property (@(posedge clock) disable iff (srst)
    (read && !ack_q && hit(address, OFS_RAW)) |=> readdata[15:0] == $past(cond_now))
    else $error("Raw condition read back wrong");

  // Main scenarios
  COV_INIT_DONE: cover property (@(posedge clock) disable iff (srst)
    state_q == ST_INIT ##1 state_q == ST_READY);
  COV_RESET_CYCLE: cover property (@(posedge clock) disable iff (srst)
    state_q == ST_HELD ##1 state_q == ST_INIT);
  COV_LOS_IRQ: cover property (@(posedge clock) disable iff (srst)
    cond_rise[0] ##1 irq);
  COV_READ_CLEAR: cover property (@(posedge clock) disable iff (srst)
    irq && rd_flags ##1 !irq);
  COV_MASKED_FLAG: cover property (@(posedge clock) disable iff (srst)
    flags_q != '0 && !irq);

endmodule : module_flag_irq

// >>> logic/module_flag_pkg.sv
// Constants, types and register map of the module flag, interrupt and reset logic
// ============================================================================
// Summary of operation
// - The host reaches monitor and configuration registers over the management bus.
// - A module reset starts only after the reset input stays low for a least pulse width.
// - Power-on, hot insertion or a reset rising edge runs a bounded init state.
// - A triggering condition drives the attention output low within a bounded time.
// - A flag condition sets its flag bit and asserts attention unless masked.
// - Entering receive loss of signal sets its flag and asserts attention.
// - Flags clear on read, and attention is released once no flag is pending.
// - Clear on read treats loss of signal, transmit fault and all flags alike.
// - Setting a mask bit stops that flag from asserting attention.
// - Clearing a mask bit restores that flag's ability to assert attention.
// - Temperature, transmit power, receive power, supply and bias are readable.
// - Attention out and reset in share one pin, reset driven by the host.
// - The management bus has a host clock and a two-way data line.
package module_flag_pkg;

  // ==========================================================================
  // Timing
  localparam int CLOCK_MHZ        = 50;
  localparam int RESET_MIN_US     = 10;
  localparam int INIT_TIME_MS     = 2;
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * CLOCK_MHZ;
  localparam int INIT_CYCLES_DEF  = INIT_TIME_MS * 1000 * CLOCK_MHZ;

  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_FLAGS  = 6'h04;
  localparam logic [5:0] OFS_MASK   = 6'h08;
  localparam logic [5:0] OFS_RAW    = 6'h0C;
  localparam logic [5:0] OFS_TEMP   = 6'h10;
  localparam logic [5:0] OFS_TXPWR  = 6'h14;
  localparam logic [5:0] OFS_RXPWR  = 6'h18;
  localparam logic [5:0] OFS_VCC    = 6'h1C;
  localparam logic [5:0] OFS_BIAS   = 6'h20;

  // Field layout and reset values
  localparam int          LANES      = 8;
  localparam int          NFLAGS     = 2 * LANES;
  localparam int          FLD_READY  = 0;
  localparam int          FLD_STATE  = 1;
  localparam int          FLD_IRQ    = 3;
  localparam logic [15:0] FLAGS_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST   = 16'h0000;

  // Management state
  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_READY = 2'b01,
    ST_HELD  = 2'b10
  } mgmt_state_t;

  // Monitor readings from the converter logic
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] tx_power;
    logic [15:0] rx_power;
    logic [15:0] supply;
    logic [15:0] bias;
  } monitor_t;

  // Lane conditions, bit 0 is lane 1
  typedef struct packed {
    logic [7:0] tx_fault;
    logic [7:0] rx_los;
  } lane_cond_t;

endpackage : module_flag_pkg

// >>> sim/host_pin_model.sv
// Host side of the shared attention and reset pin, with its pull-up
`timescale 1ns/1ns
module host_pin_model (
  input  wire logic host_reset_low,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level,
  output logic      reset_n
);
  // ==========================================================================
  // Wired level
  // shared pin level
  assign pin_level = ~(host_reset_low | (pin_oe & ~pin_out)); // Pull-up when released
  assign reset_n   = ~host_reset_low;
endmodule : host_pin_model

// >>> sim/testbench.sv
// Self-checking bench for the flag, attention and reset logic
`timescale 1ns/1ns
module testbench;
  import module_flag_pkg::*;
  logic clock, srst, read, write, host_low, present, att_n, p_out, p_oe, irq, ready;
  logic pin, rst_n, waitrequest;
  logic [5:0] address;
  logic [3:0] be;
  logic [31:0] writedata, readdata, rd, seed;
  logic [15:0] mv [5];
  lane_cond_t lc;
  monitor_t mon;
  int err_total, comparisons, cyc, b;
  module_flag_irq #(.INIT_CYCLES(20)) uut (.clock(clock), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(be),
    .readdata(readdata), .waitrequest(waitrequest), .module_reset_n_input(rst_n),
    .module_present(present), .lane_cond(lc), .monitors(mon),
    .module_attention_n_output(att_n), .attention_reset_shared_pin_out(p_out),
    .attention_reset_shared_pin_oe(p_oe), .irq(irq), .module_ready(ready));
  host_pin_model host (.host_reset_low(host_low), .pin_out(p_out), .pin_oe(p_oe),
    .pin_level(pin), .reset_n(rst_n));
  // ==========================================================================
  // Clock and timeout
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Avalon access, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) err_total++;
    rd = readdata;
    read <= 0;
    write <= 0;
    @(posedge clock);
  endtask : bus
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (ready !== 1'b1) err_total++;
  endtask : wait_ready
  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Main sequence
  initial begin
    srst = 1; read = 0; write = 0; address = 0; writedata = 0; host_low = 0; be = 4'hF;
    present = 1; lc = '0; mon = '0; seed = 32'h24b9f13f; err_total = 0; comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge clock);
    srst <= 0;
    wait_ready();
    bus(0, OFS_STATUS, 0);
    chk("status", 32'h00000003, rd);
    // Monitor readback with random values
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      mv[i] = seed[15:0];
    end
    mon <= {mv[0], mv[1], mv[2], mv[3], mv[4]};
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      bus(0, OFS_TEMP + 6'(4 * i), 0);
      chk("monitor", {16'h0000, mv[i]}, rd);
    end
    bus(0, 6'h3C, 0);
    chk("unmapped", 32'h0, rd);
    // Flag latching and clear on read, edge lanes then random
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      b = (i == 0) ? 0 : (i == 1) ? 15 : int'(seed[3:0]);
      lc <= lane_cond_t'(16'h1 << b);
      repeat (5) @(posedge clock);
      chk("irq", 1'b1, irq);
      chk("pin", 1'b0, pin);
      lc <= '0;
      repeat (5) @(posedge clock);
      chk("latched", 1'b0, att_n);
      bus(0, OFS_FLAGS, 0);
      chk("flags", 32'h1 << b, rd);
      chk("release", 1'b1, att_n);
      bus(0, OFS_FLAGS, 0);
      chk("cleared", 32'h0, rd);
    end
    // Masked flag, then mask removed
    seed = lfsr(seed);
    b = int'(seed[3:0]);
    bus(1, OFS_MASK, 32'h1 << b);
    lc <= lane_cond_t'(16'h1 << b);
    repeat (5) @(posedge clock);
    chk("masked", 1'b1, att_n);
    bus(1, OFS_MASK, 0);
    chk("unmasked", 1'b0, att_n);
    bus(0, OFS_RAW, 0);
    chk("raw", 32'h1 << b, rd);
    bus(1, OFS_MASK, 32'h0000FFFF);
    chk("fullmask", 1'b1, att_n);
    be <= 4'h1;
    bus(1, OFS_MASK, 0);
    be <= 4'hF;
    bus(0, OFS_MASK, 0);
    chk("mask", 32'h0000FF00, rd);
    chk("lanemask", (b < 8) ? 1'b0 : 1'b1, att_n);
    bus(1, OFS_MASK, 0);
    lc <= '0;
    bus(0, OFS_FLAGS, 0);
    chk("mflags", 32'h1 << b, rd);
    // Write one to clear a single flag
    lc <= lane_cond_t'(16'h8001);
    repeat (5) @(posedge clock);
    bus(1, OFS_FLAGS, 32'h1);
    lc <= '0;
    bus(0, OFS_FLAGS, 0);
    chk("w1c", 32'h00008000, rd);
    // Hot insertion restarts init
    present <= 0;
    repeat (5) @(posedge clock);
    present <= 1;
    repeat (4) @(posedge clock);
    chk("plug", 1'b0, ready);
    wait_ready();
    // Short reset pulse ignored, long one holds the module
    host_low <= 1;
    repeat (100) @(posedge clock);
    host_low <= 0;
    repeat (10) @(posedge clock);
    chk("short", 1'b1, ready);
    host_low <= 1;
    repeat (520) @(posedge clock);
    bus(0, OFS_STATUS, 0);
    chk("held", 32'h00000004, rd);
    host_low <= 0;
    repeat (3) @(posedge clock);
    chk("init", 1'b0, ready);
    wait_ready();
    chk("ready", 1'b1, ready);
    complete_run();
  end
endmodule : testbench
